// ===== design/sbp_map.svh
// Register offsets, field positions, codes and reset values of the packet handler
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH
`define SBP_OFS_CTRL 4'h0
`define SBP_OFS_STAT 4'h4
`define SBP_OFS_SELF 4'h8
`define SBP_OFS_CNT 4'hC
`define SBP_ID_SELF 2'h2
`define SBP_ID_PHY 2'h0
`define SBP_TYPE_PING 4'h0
`define SBP_TYPE_RD_BASE 4'h1
`define SBP_TYPE_RD_PAGE 4'h5
`define SBP_TYPE_RPL_BASE 4'h3
`define SBP_TYPE_RPL_PAGE 4'h7
`define SBP_TYPE_CMD 4'h8
`define SBP_CMD_SUSPEND 3'h2
`define SBP_CMD_RESUME 3'h6
`define SBP_PS_CHILD 2'h3
`define SBP_PS_PARENT 2'h2
`define SBP_PS_DISC 2'h1
`define SBP_PS_ABSENT 2'h0
`define SBP_SPD_S100 2'h0
`define SBP_SPD_S200 2'h1
`define SBP_SPD_S400 2'h2
`define SBP_CTRL_RST 17'h08200
`define SBP_GAP_RST 6'h3F
`define SBP_CTRL_SEND 16
`define SBP_REG_GAP 3'h1
`endif

// ===== design/sbp_pkg.sv
// Types shared by the packet handler and its users
package sbp_pkg;
  // Decoded content of a received self-identification packet
  typedef struct packed {
    logic ext;
    logic [2:0] seq;
    logic [5:0] node;
    logic link;
    logic [5:0] gap;
    logic [1:0] speed;
    logic contender;
    logic [2:0] pwr;
    logic [1:0] port0;
    logic initiator;
    logic more;
  } sbp_selfid_t;
  typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_SECOND} sbp_tx_state_t;
endpackage

// ===== design/sbp_packet_handler.sv
// Physical-layer control packet decoder and encoder with Avalon-MM registers
//
// Summary of operation
// - Remote command code 2h suspends the port named in the port field; the code acts only when the port field is 0.
// - Remote command code 6h resumes the port named in the port field; the code acts only when the port field is 0.
// - Self-ID packets carry a 6-bit sender node number.
// - Self-ID packets carry a link active flag, 1 when link is on.
// - Self-ID packets carry the sender's 6-bit gap setting.
// - Speed code 00b/01b/10b means 100/200/400 Mbit/s.
// - Self-ID contender flag is 1 when sender can be resource manager.
// - 3-bit power class encodes supply or draw of cable power.
// - Port state 11b child, 10b parent, 01b disconnected, 00b absent.
// - Self-ID initiator flag is 1 when sender started the bus reset.
// - Self-ID more flag is 1 when another packet from that node follows.
// - Extended self-ID packets carry a sequence index.
// - Configuration packets carry a 6-bit target root node.
// - Root valid with a foreign target root clears the root holdoff.
// - Root valid with our own node as target sets the root holdoff.
// - Gap valid copies the packet's gap setting into our own.
// - Ping and remote access packets carry a 6-bit destination node.
// - Type code 00h marks a ping.
// - A ping for this node makes it send its self-ID packet.
// - Type 01h reads base registers 0 to 7; type 05h reads paged ones.
// - Remote access carries a 3-bit page field.
// - Remote access carries a 4-bit port field.
// - Remote access carries a 3-bit register address.
// - Remote access for this node is answered with a reply packet.
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "sbp_map.svh"
module sbp_packet_handler #(
  parameter int NUM_PORTS = 1
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic RX_VALID,
  input wire logic [31:0] RX_DATA,
  output logic TX_VALID,
  output logic [31:0] TX_DATA,
  input wire logic TX_READY,
  output sbp_pkg::sbp_selfid_t LAST_SELFID,
  output logic ROOT_HOLDOFF_FLAG,
  output logic [5:0] GAP_COUNT,
  output logic PORT_SUSPENDED
);
  import sbp_pkg::*;

  logic [16:0] ctrl;
  logic [31:0] rx_first;
  logic rx_have;
  logic pkt_ok;
  logic pkt_bad;
  logic [7:0] ping_cnt;
  logic [7:0] bad_cnt;
  logic pend_self;
  logic pend_reply;
  logic [31:0] reply_q;
  sbp_tx_state_t tx_state;
  logic [31:0] wmask;
  logic wr_ok;

  // Control fields held in the control register
  logic [5:0] node_number_field;
  logic link_on;
  logic contender;
  logic [1:0] speed_code;
  logic [2:0] pwr;
  logic initiator;
  logic [1:0] port0_state;
  assign node_number_field = ctrl[5:0];
  assign link_on = ctrl[6];
  assign contender = ctrl[7];
  assign speed_code = ctrl[9:8];
  assign pwr = ctrl[12:10];
  assign initiator = ctrl[13];
  assign port0_state = ctrl[15:14];

  // Field slices of the first received quadlet
  logic [1:0] q_id;
  logic [5:0] q_node;
  logic q_r;
  logic q_t;
  logic [5:0] q_gap;
  logic [3:0] q_type;
  logic [2:0] q_page;
  logic [3:0] q_port;
  logic [2:0] q_reg;
  logic [2:0] q_cmd;
  logic is_cfg;
  logic for_me;
  assign q_id = rx_first[31:30];
  assign q_node = rx_first[29:24];
  assign q_r = rx_first[23];
  assign q_t = rx_first[22];
  assign q_gap = rx_first[21:16];
  assign q_type = rx_first[21:18];
  assign q_page = rx_first[17:15];
  assign q_port = rx_first[14:11];
  assign q_reg = rx_first[10:8];
  assign q_cmd = rx_first[2:0];
  // Extended packets have both valid flags clear, so either flag marks configuration
  assign is_cfg = (q_id == `SBP_ID_PHY) && (q_r || q_t);
  assign for_me = (q_id == `SBP_ID_PHY) && !is_cfg && (q_node == node_number_field);

  logic got_ping;
  logic got_read;
  logic got_cmd;
  assign got_ping = pkt_ok && for_me && (q_type == `SBP_TYPE_PING);
  assign got_read = pkt_ok && for_me && ((q_type == `SBP_TYPE_RD_BASE) || (q_type == `SBP_TYPE_RD_PAGE));
  assign got_cmd = pkt_ok && for_me && (q_type == `SBP_TYPE_CMD);

  assign pkt_ok = RX_VALID && rx_have && (RX_DATA == ~rx_first);
  assign pkt_bad = RX_VALID && rx_have && (RX_DATA != ~rx_first);

  // Quadlet pairing: an odd quadlet after a discard starts a fresh pair
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rx_have <= 1'b0;
      rx_first <= 32'h0000_0000;
    end else if (RX_VALID) begin
      if (!rx_have) begin
        rx_first <= RX_DATA;
      end
      rx_have <= !rx_have;
    end
  end

  // Self-ID quadlet that this node sends
  logic [31:0] own_selfid;
  assign own_selfid = {`SBP_ID_SELF, node_number_field, 1'b0, link_on, GAP_COUNT, speed_code, 2'b00,
    contender, pwr, (NUM_PORTS > 0) ? port0_state : `SBP_PS_ABSENT, `SBP_PS_ABSENT, `SBP_PS_ABSENT,
    initiator, 1'b0};

  // Base register image readable from afar; paged registers live elsewhere and read as zero
  logic [7:0] reg_data;
  always_comb begin
    reg_data = 8'h00;
    if (q_type == `SBP_TYPE_RD_BASE) begin
      if (q_reg == 3'h0) begin
        reg_data = {node_number_field, 2'b00};
      end else if (q_reg == `SBP_REG_GAP) begin
        reg_data = {ROOT_HOLDOFF_FLAG, 1'b0, GAP_COUNT};
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ROOT_HOLDOFF_FLAG <= 1'b0;
    end else if (pkt_ok && is_cfg && q_r) begin
      ROOT_HOLDOFF_FLAG <= (q_node == node_number_field);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      GAP_COUNT <= `SBP_GAP_RST;
    end else if (pkt_ok && is_cfg && q_t) begin
      GAP_COUNT <= q_gap;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PORT_SUSPENDED <= 1'b0;
    end else if (got_cmd && (q_port == 4'h0)) begin
      if (q_cmd == `SBP_CMD_SUSPEND) begin
        PORT_SUSPENDED <= 1'b1;
      end else if (q_cmd == `SBP_CMD_RESUME) begin
        PORT_SUSPENDED <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      LAST_SELFID <= '0;
    end else if (pkt_ok && (q_id == `SBP_ID_SELF)) begin
      LAST_SELFID.node <= q_node;
      LAST_SELFID.more <= rx_first[0];
      LAST_SELFID.ext <= rx_first[23];
      if (rx_first[23]) begin
        LAST_SELFID.seq <= rx_first[22:20];
      end else begin
        LAST_SELFID.seq <= 3'h0;
        LAST_SELFID.link <= rx_first[22];
        LAST_SELFID.gap <= rx_first[21:16];
        LAST_SELFID.speed <= rx_first[15:14];
        LAST_SELFID.contender <= rx_first[11];
        LAST_SELFID.pwr <= rx_first[10:8];
        LAST_SELFID.port0 <= rx_first[7:6];
        LAST_SELFID.initiator <= rx_first[1];
      end
    end
  end

  // Event counters, wrapping, for software visibility
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ping_cnt <= 8'h00;
      bad_cnt <= 8'h00;
    end else begin
      if (got_ping) begin
        ping_cnt <= ping_cnt + 8'h01;
      end
      if (pkt_bad) begin
        bad_cnt <= bad_cnt + 8'h01;
      end
    end
  end

  // Pending transmit requests; a new request wins over the clear by launch
  logic take_self;
  logic take_reply;
  assign take_self = (tx_state == TX_IDLE) && pend_self;
  assign take_reply = (tx_state == TX_IDLE) && !pend_self && pend_reply;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pend_self <= 1'b0;
      pend_reply <= 1'b0;
      reply_q <= 32'h0000_0000;
    end else begin
      pend_self <= got_ping || (wr_ok && (AVS_ADDRESS == `SBP_OFS_CTRL) && wmask[`SBP_CTRL_SEND] &&
        AVS_WRITEDATA[`SBP_CTRL_SEND]) || (pend_self && !take_self);
      pend_reply <= got_read || (pend_reply && !take_reply);
      if (got_read) begin
        reply_q <= {`SBP_ID_PHY, node_number_field, 2'b00,
          (q_type == `SBP_TYPE_RD_BASE) ? `SBP_TYPE_RPL_BASE : `SBP_TYPE_RPL_PAGE,
          q_page, q_port, q_reg, reg_data};
      end
    end
  end

  // Transmit sequencer: first quadlet, then its inverse, each held until taken
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      tx_state <= TX_IDLE;
      TX_VALID <= 1'b0;
      TX_DATA <= 32'h0000_0000;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (take_self) begin
            TX_DATA <= own_selfid;
            TX_VALID <= 1'b1;
            tx_state <= TX_FIRST;
          end else if (take_reply) begin
            TX_DATA <= reply_q;
            TX_VALID <= 1'b1;
            tx_state <= TX_FIRST;
          end
        end
        TX_FIRST: begin
          if (TX_READY) begin
            TX_DATA <= ~TX_DATA;
            tx_state <= TX_SECOND;
          end
        end
        default: begin
          if (TX_READY) begin
            TX_VALID <= 1'b0;
            tx_state <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // Byte lane mask for writes
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[b*8 +: 8] = {8{AVS_BYTEENABLE[b]}};
    end
  endgenerate
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;

  // Control register; the send bit is a strobe and is never stored
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl <= `SBP_CTRL_RST;
    end else if (wr_ok && (AVS_ADDRESS == `SBP_OFS_CTRL)) begin
      ctrl[15:0] <= (ctrl[15:0] & ~wmask[15:0]) | (AVS_WRITEDATA[15:0] & wmask[15:0]);
    end
  end

  // Bus slave: one wait cycle, read data captured as the wait ends
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b0;
      if (!AVS_READ) begin
        AVS_READDATA <= 32'h0000_0000;
      end else if (AVS_ADDRESS == `SBP_OFS_CTRL) begin
        AVS_READDATA <= {16'h0000, ctrl[15:0]};
      end else if (AVS_ADDRESS == `SBP_OFS_STAT) begin
        AVS_READDATA <= {14'h0000, tx_state != TX_IDLE, PORT_SUSPENDED, 2'b00, GAP_COUNT, 7'h00,
          ROOT_HOLDOFF_FLAG};
      end else if (AVS_ADDRESS == `SBP_OFS_SELF) begin
        AVS_READDATA <= {5'h00, LAST_SELFID};
      end else if (AVS_ADDRESS == `SBP_OFS_CNT) begin
        AVS_READDATA <= {16'h0000, ping_cnt, bad_cnt};
      end else begin
        AVS_READDATA <= 32'h0000_0000;
      end
    end else begin
      AVS_WAITREQUEST <= 1'b1;
    end
  end

  // Checks on received-packet effects and on transmitted quadlets
  // discard counts
  bad_count_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    pkt_bad |=> bad_cnt == $past(bad_cnt) + 8'h01) else $error("bad pair not counted");
  suspend_port_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    got_cmd && q_port == 4'h0 && q_cmd == `SBP_CMD_SUSPEND |=> PORT_SUSPENDED)
    else $error("suspend ignored");
  resume_port_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    got_cmd && q_port == 4'h0 && q_cmd == `SBP_CMD_RESUME |=> !PORT_SUSPENDED)
    else $error("resume ignored");
  holdoff_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    pkt_ok && is_cfg && q_r && q_node != node_number_field |=> !ROOT_HOLDOFF_FLAG)
    else $error("holdoff not cleared");
  holdoff_set_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    pkt_ok && is_cfg && q_r && q_node == node_number_field |=> ROOT_HOLDOFF_FLAG)
    else $error("holdoff not set");
  gap_copy_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    pkt_ok && is_cfg && q_t |=> GAP_COUNT == $past(q_gap)) else $error("gap not copied");
  ping_answer_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    got_ping |=> pend_self) else $error("ping not answered");
  reply_fill_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    got_read |=> pend_reply && reply_q[14:8] == $past(rx_first[14:8])) else $error("bad reply");
  selfid_out_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    take_self |=> TX_VALID && TX_DATA[29:24] == node_number_field && TX_DATA[5:2] == 4'h0)
    else $error("self-ID malformed");
  tx_inverse_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    tx_state == TX_FIRST && TX_READY |=> TX_DATA == ~$past(TX_DATA) && TX_VALID)
    else $error("second quadlet not inverse");
  selfid_node_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    pkt_ok && q_id == `SBP_ID_SELF |=> LAST_SELFID.node == $past(q_node))
    else $error("self-ID node lost");
  // Bus answers one cycle after the request is taken
  bus_answer_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("bus answer late");

  ping_seen_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N) got_ping);
  cfg_seen_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N) pkt_ok && is_cfg);
  suspend_seen_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(PORT_SUSPENDED));
  discard_seen_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N) pkt_bad);
endmodule

// ===== dv/sbp_peer_node.sv
// Far-side node model: sends quadlet pairs and sinks transmitted quadlets with stalls
`timescale 1ns/1ps
module sbp_peer_node (
  input wire logic clk,
  input wire logic rst_n,
  output logic rx_valid,
  output logic [31:0] rx_data,
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  output logic tx_ready
);
  logic [31:0] seen[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 32'h0;
    tx_ready = 1'b0;
  end
  // Random stalls force the sender to hold each quadlet until taken
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      seen.push_back(tx_data);
    end
    tx_ready <= rst_n && ($urandom % 4 != 0);
  end
  // One packet as a quadlet and its inverse; a corrupted pair repeats the quadlet
  task automatic send_pkt(input logic [31:0] q, input bit bad);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= q;
    @(posedge clk);
    rx_data <= bad ? q : ~q;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= bad ? ~q : q; // Idle line repeats the quadlet, or shows its inverse after a corrupted pair
  endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the packet handler against a reference model
`timescale 1ns/1ps
module testbench;
  import sbp_pkg::*;
  logic clk, rst_n, avs_read, avs_write, avs_waitreq, rx_valid, tx_valid, tx_ready, holdoff, susp;
  logic root_holdoff, port_susp;
  logic [3:0] avs_address, avs_be;
  logic [31:0] avs_wdata, avs_rdata, rx_data, tx_data, rd, ctrl, q;
  logic [5:0] gap_count, node, gap, r;
  sbp_selfid_t last_selfid;
  int n_fail = 0, num_checks = 0, cycles = 0, pings, bad;
  sbp_packet_handler dut_u (.SYS_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_wdata), .AVS_BYTEENABLE(avs_be), .AVS_READDATA(avs_rdata),
    .AVS_WAITREQUEST(avs_waitreq), .RX_VALID(rx_valid), .RX_DATA(rx_data), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_READY(tx_ready), .LAST_SELFID(last_selfid), .ROOT_HOLDOFF_FLAG(root_holdoff),
    .GAP_COUNT(gap_count), .PORT_SUSPENDED(port_susp));
  sbp_peer_node peer_u (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Avalon request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_wdata <= d;
    avs_be <= be;
    do @(posedge clk); while (avs_waitreq !== 1'b0);
    rd = avs_rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(what, e, rd);
  endtask
  function automatic logic [31:0] stat_exp();
    return {14'h0, 1'b0, susp, 2'h0, gap, 7'h0, holdoff};
  endfunction
  // Own self-ID: ports 1 and 2 are not implemented and go out as absent
  function automatic logic [31:0] own_selfid();
    return {2'b10, ctrl[5:0], 1'b0, ctrl[6], gap, ctrl[9:8], 2'b00, ctrl[7], ctrl[12:10], ctrl[15:14],
      4'h0, ctrl[13], 1'b0};
  endfunction
  task automatic rx(input logic [31:0] p, input bit b);
    peer_u.send_pkt(p, b);
    @(posedge clk);
    #1;
  endtask
  task automatic chk_flags();
    chk("holdoff", {31'h0, holdoff}, {31'h0, root_holdoff});
    chk("gap", {26'h0, gap}, {26'h0, gap_count});
    chk("suspend", {31'h0, susp}, {31'h0, port_susp});
  endtask
  task automatic tx_expect(input logic [31:0] e);
    while (peer_u.seen.size() < 2) @(posedge clk);
    chk("tx first", e, peer_u.seen[0]);
    chk("tx second", ~e, peer_u.seen[1]);
    peer_u.seen.delete();
  endtask
  initial begin
    void'($urandom(32'hDD646DBF));
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_wdata = 32'h0;
    avs_be = 4'h0;
    ctrl = 32'h08200;
    node = 6'h0;
    gap = 6'h3F;
    holdoff = 1'b0;
    susp = 1'b0;
    pings = 0;
    bad = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_flags();
    rdchk(4'h0, ctrl, "ctrl reset");
    rdchk(4'h4, stat_exp(), "status reset");
    rdchk(4'h2, 32'h0, "unmapped");
    bus(1'b1, 4'h4, $urandom, 4'hF);
    rdchk(4'h4, stat_exp(), "status ignores write");
    // Every speed, power class and port state goes out in a ping-triggered self-ID
    for (int i = 0; i < 8; i++) begin
      node = 6'($urandom);
      ctrl = {16'h0, 2'(3 - i % 4), 1'($urandom), 3'(i), 2'(i % 3), 2'($urandom), node};
      bus(1'b1, 4'h0, ctrl, 4'h3);
      rdchk(4'h0, ctrl, "ctrl");
      rx({2'b00, node, 24'h0}, 1'b0);
      pings++;
      tx_expect(own_selfid());
    end
    bus(1'b1, 4'h0, 32'h10000, 4'h4);
    tx_expect(own_selfid());
    // Configuration: own and foreign roots, gap updates with and without root
    for (int j = 0; j < 6; j++) begin
      r = (j % 2 == 0) ? node : node ^ 6'(1 + $urandom % 63);
      q = {2'b00, r, 1'(j != 2), 1'(j >= 2), 6'($urandom), 16'h0};
      if (j != 2) holdoff = (r == node);
      if (j >= 2) gap = q[21:16];
      rx(q, 1'b0);
      chk_flags();
    end
    rx({2'b00, node, 2'b11, ~gap, 16'h0}, 1'b1);
    bad++;
    chk_flags();
    // Received self-ID fields, plain then extended with sequence index
    for (int k = 0; k < 4; k++) begin
      q = {2'b10, 6'($urandom), 1'b0, 1'($urandom), 6'($urandom), 2'(k % 3), 2'b00, 1'($urandom),
        3'($urandom), 2'(k), 4'h0, 1'($urandom), 1'($urandom)};
      rx(q, 1'b0);
      chk("selfid", {1'b0, 3'h0, q[29:24], q[22:14], q[11:6], q[1:0]}, {last_selfid.ext, last_selfid.seq,
        last_selfid.node, last_selfid.link, last_selfid.gap, last_selfid.speed, last_selfid.contender,
        last_selfid.pwr,
        last_selfid.port0, last_selfid.initiator, last_selfid.more});
      q = {2'b10, 6'($urandom), 1'b1, 3'(k + 4), 19'h0, 1'(k)};
      rx(q, 1'b0);
      chk("ext selfid", {1'b1, q[22:20], q[29:24], q[0]}, {last_selfid.ext, last_selfid.seq,
        last_selfid.node, last_selfid.more});
    end
    // Remote reads of base registers 0, 1, 5 and one paged read
    for (int m = 0; m < 4; m++) begin
      r = 6'($urandom);
      // Register addresses 0, 1, 5, then 2 for the paged read
      q = {2'b00, node, 2'b00, (m == 3) ? 4'h5 : 4'h1, r[2:0], 1'b0, r[5:3], 3'(m * m + m / 2), 8'h0};
      rx(q, 1'b0);
      q[21:18] = (m == 3) ? 4'h7 : 4'h3;
      q[7:0] = (m == 0) ? {node, 2'b00} : (m == 1) ? {holdoff, 1'b0, gap} : 8'h0;
      tx_expect(q);
    end
    // Suspend and resume; commands for another port are ignored
    for (int c = 0; c < 4; c++) begin
      rx({2'b00, node, 2'b00, 4'h8, 3'h0, 4'(c % 2), 8'h0, (c < 2) ? 3'h2 : 3'h6}, 1'b0);
      // Port 1 does not exist, so its commands leave the port 0 state alone
      susp = 1'(c < 2);
      chk_flags();
    end
    rdchk(4'h4, stat_exp(), "status");
    rdchk(4'hC, {16'h0, 8'(pings), 8'(bad)}, "counters");
    rx({2'b00, node + 6'h1, 24'h0}, 1'b0);
    repeat (20) @(posedge clk);
    chk("foreign ping tx", 32'h0, 32'(peer_u.seen.size()));
    print_verdict();
  end
endmodule
